// ==== include/shift_pkg.sv ====
package shift_pkg;
	// tick and interval counts: intervals in ms, then converted to 100 ms ticks
	localparam int CLK_HZ = 40000000;
	localparam int TICK_MS = 100;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int LAMP_CHECK_MS = 600;
	localparam int DIAG_MS = 1500;
	localparam int BLINK_MS = 300;
	localparam int COND_HOLD_MS = 2000;
	localparam int FIRST_DELAY_MS = 3000;
	localparam int TIMEOUT_EXTRA_MS = 5000;
	localparam int NORMAL_HL_MS = 1500;
	localparam int NORMAL_RANGE_MS = 3000;
	localparam int COMP_MS = 5000;
	localparam int HUB_DELAY_MS = 4000;
	localparam int CLUTCH_OFF_MS = 5000;
	localparam logic [7:0] LAMP_CHECK_T = 8'(LAMP_CHECK_MS / TICK_MS);
	localparam logic [7:0] DIAG_T = 8'(DIAG_MS / TICK_MS);
	localparam logic [7:0] BLINK_T = 8'(BLINK_MS / TICK_MS);
	localparam logic [7:0] COND_HOLD_T = 8'(COND_HOLD_MS / TICK_MS);
	localparam logic [7:0] FIRST_DELAY_T = 8'(FIRST_DELAY_MS / TICK_MS);
	localparam logic [7:0] TIMEOUT_HL_T = 8'((NORMAL_HL_MS + TIMEOUT_EXTRA_MS) / TICK_MS);
	localparam logic [7:0] TIMEOUT_RANGE_T = 8'((NORMAL_RANGE_MS + TIMEOUT_EXTRA_MS) / TICK_MS);
	localparam logic [7:0] COMP_T = 8'(COMP_MS / TICK_MS);
	localparam logic [7:0] HUB_DELAY_T = 8'(HUB_DELAY_MS / TICK_MS);
	localparam logic [7:0] CLUTCH_OFF_T = 8'(CLUTCH_OFF_MS / TICK_MS);
	localparam logic [7:0] LOW_SPEED_KPH = 8'h02;
	// encoder codes, bit 3 is the msb
	localparam logic [3:0] POS_2H = 4'ha;
	localparam logic [3:0] POS_4H = 4'h3;
	localparam logic [3:0] POS_4L = 4'hc;
	localparam logic [3:0] POS_STOP = 4'h0;
	localparam logic [3:0] POS_OFF = 4'hf;
	localparam logic [3:0] POS_ZONE1 = 4'h2;
	localparam logic [3:0] POS_ZONE2 = 4'h6;
	localparam logic [3:0] POS_ZONE4 = 4'h1;
	localparam logic [3:0] POS_ZONE5 = 4'h9;
	localparam logic [3:0] POS_ZONE6 = 4'h8;
	typedef enum logic [1:0] {RANGE_2H, RANGE_4H, RANGE_4L, RANGE_NONE} range_t;
	typedef enum logic [2:0] {ST_INIT, ST_IDLE, ST_HOLD, ST_DELAY, ST_RUN, ST_COMP}
		state_t;
endpackage

// ==== rtl/transfer_controller.sv ====
`timescale 1ns/10ps
// Contract
// - forward polarity toward four-wheel, reverse swaps
// - decode encoder codes into ranges and zones
// - both range lamps lit 0.6 s
// - clutch and hub energised 1.5 s
// - mismatch at start moves toward selector
// - range lamp toggles every 0.3 s
// - conditions held 2 s before motor
// - first motor run waits three seconds
// - conditions ignored once motor started
// - 2H/4H shift needs only battery, motor ok
// - 4H/4L shift needs speed below 2 kph
// - high-to-low needs clutch or neutral
// - step one range at a time until reached
// - started shift finishes without ignition
// - overrun of 5 s is timeout, motor stopped
// - fault before start counts as fault
// - motor stops at target code
// - encoder fault drives low-to-high 5 s
// - clutch coil on leaving two-wheel high
// - hub solenoid 4 s after reaching 4H
// - clutch coil off 5 s after hub on
// - high lamp on in 4H, off in 2H
// - selector: in1 low 2H, open 4H, in2 low 4L
module transfer_controller
	import shift_pkg::*;
#(
	parameter int TICK_CYCLES_P = TICK_CYCLES
) (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic ignition_i,
	input wire logic select_2h_n_i,
	input wire logic select_4l_n_i,
	input wire logic [3:0] encoder_i,
	input wire logic [7:0] speed_kph_i,
	input wire logic clutch_pressed_i,
	input wire logic neutral_i,
	input wire logic battery_ok_i,
	input wire logic motor_ok_i,
	output logic motor_drive_fwd_o,
	output logic motor_drive_rev_o,
	output logic clutch_coil_drive_o,
	output logic hub_solenoid_o,
	output logic high_range_lamp_o,
	output logic low_range_lamp_o,
	output logic fault_lamp_o,
	output logic lamp_check_o,
	output logic timeout_fault_o,
	output logic encoder_fault_o
);
	if (TICK_CYCLES_P < 1 || TICK_CYCLES_P > 16777215) begin : g_bad_tick
		$error("TICK_CYCLES_P out of range");
	end
	// two-stage synchronisers for every pin input except battery_ok_i and motor_ok_i
	logic [8:0] pin_s1, pin_s2;
	logic [7:0] speed_s1, speed_s2;
	always_ff @(posedge clock_i) begin
		pin_s1 <= {ignition_i, select_2h_n_i, select_4l_n_i, encoder_i, clutch_pressed_i,
			neutral_i};
		pin_s2 <= pin_s1;
		speed_s1 <= speed_kph_i;
		speed_s2 <= speed_s1;
	end
	logic ign, sel_2h_n, sel_4l_n, clutch_in, neutral_in;
	logic [3:0] enc;
	assign {ign, sel_2h_n, sel_4l_n, enc, clutch_in, neutral_in} = pin_s2;

	// selector decode; both grounded is treated as no valid request
	range_t sel;
	always_comb begin
		if (!sel_2h_n && sel_4l_n) sel = RANGE_2H;
		else if (sel_2h_n && sel_4l_n) sel = RANGE_4H;
		else if (sel_2h_n && !sel_4l_n) sel = RANGE_4L;
		else sel = RANGE_NONE;
	end

	// encoder decode: zones are legal travel, anything else is a fault
	range_t pos;
	logic enc_bad, lo_zone;
	always_comb begin
		pos = RANGE_NONE;
		enc_bad = 1'b0;
		lo_zone = (enc == POS_ZONE1) || (enc == POS_ZONE2); // plate between 2H and 4H
		case (enc)
			POS_2H: pos = RANGE_2H;
			POS_4H: pos = RANGE_4H;
			POS_4L: pos = RANGE_4L;
			POS_ZONE1, POS_ZONE2, POS_ZONE4, POS_ZONE5, POS_ZONE6: pos = RANGE_NONE;
			POS_STOP, POS_OFF: enc_bad = 1'b1;
			default: enc_bad = 1'b1;
		endcase
	end
	// fixed-rate tick from the system clock
	logic [23:0] div, next_div;
	logic tick;
	always_comb begin
		tick = (div == 24'(TICK_CYCLES_P - 1));
		next_div = tick ? 24'h000000 : div + 24'h000001;
	end
	always_ff @(posedge clock_i) begin
		if (reset_i) div <= 24'h000000;
		else div <= next_div;
	end
	// main shift sequencer
	state_t state, next_state;
	range_t target, next_target, settled, next_settled, step;
	logic [7:0] cnt, next_cnt, blink_cnt, next_blink_cnt;
	logic first_run, next_first_run, blink, next_blink;
	logic to_fault, next_to_fault, enc_fault, next_enc_fault, ign_d, next_ign_d;
	logic fwd, rev, cond_ok;
	// next range one step toward selector
	always_comb begin
		if (settled == RANGE_2H) step = RANGE_4H;
		else if (settled == RANGE_4L) step = RANGE_4H;
		else step = sel;
		if (sel == settled) step = settled;
	end
	// shift preconditions
	always_comb begin
		cond_ok = battery_ok_i && motor_ok_i && !enc_bad;
		if ((settled == RANGE_4H && step == RANGE_4L) || (settled == RANGE_4L)) begin
			cond_ok = cond_ok && (speed_s2 < LOW_SPEED_KPH);
		end
		if (settled == RANGE_4H && step == RANGE_4L) begin
			cond_ok = cond_ok && (clutch_in || neutral_in);
		end
	end
	always_comb begin
		next_state = state;
		next_target = target;
		next_settled = settled;
		next_cnt = (tick && cnt != 8'hff) ? cnt + 8'h01 : cnt;
		next_first_run = first_run;
		next_to_fault = to_fault;
		next_enc_fault = enc_fault;
		next_ign_d = ign;
		fwd = 1'b0;
		rev = 1'b0;
		case (state)
			ST_INIT: begin
				if (!ign_d && ign) next_cnt = 8'h00;
				if (cnt >= DIAG_T) begin
					next_settled = pos;
					next_state = ST_IDLE;
				end
			end
			ST_IDLE: begin
				next_cnt = 8'h00;
				if (ign && sel != RANGE_NONE && step != settled) begin
					next_target = step;
					next_state = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (!cond_ok || step != target || !ign) begin
					next_state = ST_IDLE;
				end else if (cnt >= COND_HOLD_T) begin
					next_cnt = 8'h00;
					next_state = first_run ? ST_DELAY : ST_RUN;
				end
			end
			ST_DELAY: begin
				// conditions no longer looked at, ignition loss ignored
				if (enc_bad) begin
					next_enc_fault = 1'b1;
					next_cnt = 8'h00;
					next_state = ST_COMP;
				end else if (cnt >= FIRST_DELAY_T) begin
					next_first_run = 1'b0;
					next_cnt = 8'h00;
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				// forward moves toward low range, reverse toward two-wheel
				// from an unknown start the zone tells which side of 4H the plate is on
				if (target == RANGE_4L || (target == RANGE_4H &&
						(settled == RANGE_2H || lo_zone))) begin
					fwd = 1'b1;
				end else begin
					rev = 1'b1;
				end
				if (pos == target) begin
					next_settled = target;
					next_state = ST_IDLE;
				end else if (enc_bad) begin
					next_enc_fault = 1'b1;
					next_cnt = 8'h00;
					next_state = ST_COMP;
				end else if (cnt >= ((settled == RANGE_4L || target == RANGE_4L) ?
						TIMEOUT_RANGE_T : TIMEOUT_HL_T)) begin
					next_to_fault = 1'b1;
					next_cnt = 8'h00;
					next_state = ST_COMP;
				end
			end
			ST_COMP: begin
				if (cnt < COMP_T) begin
					rev = enc_fault;
				end else begin
					next_settled = pos;
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_INIT;
		endcase
	end
	// lamp blink counter, runs only with the motor
	always_comb begin
		next_blink_cnt = blink_cnt;
		next_blink = blink;
		if (state != ST_RUN) begin
			next_blink_cnt = 8'h00;
			next_blink = 1'b0;
		end else if (tick) begin
			if (blink_cnt >= BLINK_T - 8'h01) begin
				next_blink_cnt = 8'h00;
				next_blink = !blink;
			end else begin
				next_blink_cnt = blink_cnt + 8'h01;
			end
		end
	end
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			state <= ST_INIT;
			target <= RANGE_2H;
			settled <= RANGE_2H;
			cnt <= 8'h00;
			first_run <= 1'b1;
			to_fault <= 1'b0;
			enc_fault <= 1'b0;
			ign_d <= 1'b0;
			blink_cnt <= 8'h00;
			blink <= 1'b0;
		end else begin
			state <= next_state;
			target <= next_target;
			settled <= next_settled;
			cnt <= next_cnt;
			first_run <= next_first_run;
			to_fault <= next_to_fault;
			enc_fault <= next_enc_fault;
			ign_d <= next_ign_d;
			blink_cnt <= next_blink_cnt;
			blink <= next_blink;
		end
	end
	// synchronisation: clutch on leaving 2H, hub after 4H, clutch off later
	typedef enum logic [1:0] {SY_OFF, SY_CLUTCH, SY_HUB_WAIT, SY_HUB} sync_t;
	sync_t sync, next_sync;
	logic [7:0] sync_cnt, next_sync_cnt;
	logic hub_on, next_hub_on;
	always_comb begin
		next_sync = sync;
		next_hub_on = hub_on;
		next_sync_cnt = (tick && sync_cnt != 8'hff) ? sync_cnt + 8'h01 : sync_cnt;
		case (sync)
			SY_OFF: begin
				next_sync_cnt = 8'h00;
				if (state == ST_HOLD && settled == RANGE_2H && sel != RANGE_2H) begin
					next_sync = SY_CLUTCH;
				end
			end
			SY_CLUTCH: begin
				next_sync_cnt = 8'h00;
				if (settled == RANGE_4H || settled == RANGE_4L) next_sync = SY_HUB_WAIT;
				else if (state == ST_IDLE && sel == RANGE_2H) next_sync = SY_OFF;
			end
			SY_HUB_WAIT: begin
				if (sync_cnt >= HUB_DELAY_T) begin
					next_hub_on = 1'b1;
					next_sync_cnt = 8'h00;
					next_sync = SY_HUB;
				end
			end
			SY_HUB: begin
				if (sync_cnt >= CLUTCH_OFF_T) next_sync = SY_OFF;
			end
			default: next_sync = SY_OFF;
		endcase
		if (settled == RANGE_2H && state == ST_IDLE) next_hub_on = 1'b0;
	end
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			sync <= SY_OFF;
			sync_cnt <= 8'h00;
			hub_on <= 1'b0;
		end else begin
			sync <= next_sync;
			sync_cnt <= next_sync_cnt;
			hub_on <= next_hub_on;
		end
	end
	// registered outputs
	logic init_lamps, init_diag, run_low;
	always_comb begin
		init_lamps = (state == ST_INIT) && (cnt < LAMP_CHECK_T);
		init_diag = (state == ST_INIT) && (cnt < DIAG_T);
		run_low = (target == RANGE_4L) || (settled == RANGE_4L);
	end
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			motor_drive_fwd_o <= 1'b0;
			motor_drive_rev_o <= 1'b0;
			clutch_coil_drive_o <= 1'b0;
			hub_solenoid_o <= 1'b0;
			high_range_lamp_o <= 1'b0;
			low_range_lamp_o <= 1'b0;
			fault_lamp_o <= 1'b0;
			lamp_check_o <= 1'b0;
			timeout_fault_o <= 1'b0;
			encoder_fault_o <= 1'b0;
		end else begin
			motor_drive_fwd_o <= fwd;
			motor_drive_rev_o <= rev;
			clutch_coil_drive_o <= init_diag || sync == SY_CLUTCH || sync == SY_HUB_WAIT ||
				sync == SY_HUB;
			hub_solenoid_o <= init_diag || hub_on;
			lamp_check_o <= init_lamps;
			// while running, the lamp of the moving range blinks
			if (init_lamps) begin
				high_range_lamp_o <= 1'b1;
				low_range_lamp_o <= 1'b1;
			end else if (state == ST_RUN) begin
				high_range_lamp_o <= run_low ? 1'b0 : blink;
				low_range_lamp_o <= run_low ? blink : 1'b0;
			end else begin
				high_range_lamp_o <= settled == RANGE_4H;
				low_range_lamp_o <= settled == RANGE_4L;
			end
			fault_lamp_o <= to_fault || enc_fault;
			timeout_fault_o <= to_fault;
			encoder_fault_o <= enc_fault;
		end
	end
endmodule

// ==== tb/shift_motor_model.sv ====
`timescale 1ns/10ps
// motor plate walks one zone every 8 clocks while driven; stall jams it
module shift_motor_model (
	input wire logic clock_i,
	input wire logic fwd_i,
	input wire logic rev_i,
	input wire logic stall_i,
	input wire logic fault_i,
	output logic [3:0] encoder_o
);
	logic [3:0] code [10] = '{4'h0, 4'ha, 4'h2, 4'h6, 4'h3, 4'h1, 4'h9, 4'h8, 4'hc, 4'h0};
	int idx = 1;
	int step = 0;
	// a broken plate reads all ones
	assign encoder_o = fault_i ? 4'hf : code[idx];
	// end stops read as zero, so an overrun shows up as a bad code
	always @(posedge clock_i) begin
		step <= (fwd_i || rev_i) && step < 7 ? step + 1 : 0;
		if (step == 7 && !stall_i && fwd_i && idx < 9)
			idx <= idx + 1;
		if (step == 7 && !stall_i && rev_i && idx > 0)
			idx <= idx - 1;
	end
endmodule

// ==== tb/transfer_controller_chk.sv ====
`timescale 1ns/10ps
// watches the controller outputs; the lamp-check and hub windows scale with the tick length
module transfer_controller_chk
	import shift_pkg::*;
#(
	parameter int TICK_CYCLES_P = 4
) (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic [3:0] encoder_i,
	input wire logic motor_drive_fwd_o,
	input wire logic motor_drive_rev_o,
	input wire logic clutch_coil_drive_o,
	input wire logic hub_solenoid_o,
	input wire logic high_range_lamp_o,
	input wire logic low_range_lamp_o,
	input wire logic fault_lamp_o,
	input wire logic lamp_check_o,
	input wire logic timeout_fault_o,
	input wire logic encoder_fault_o
);
	localparam int LC_LO = 5 * TICK_CYCLES_P;
	localparam int HUB_LO = 38 * TICK_CYCLES_P;
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	// interval checks are low bounds only; reactions must come within 4 cycles
	drive_excl_a: assert property (
		!(motor_drive_fwd_o && motor_drive_rev_o)) else $error("drives overlap");
	check_window_a: assert property (
		$fell(lamp_check_o) |-> $past(lamp_check_o, LC_LO)) else $error("lamp check short");
	diag_window_a: assert property (
		$rose(lamp_check_o) |-> ##[0:2] (clutch_coil_drive_o && hub_solenoid_o) [*8])
		else $error("coil test missing");
	motor_stop_a: assert property (
		motor_drive_fwd_o && encoder_i == POS_4L |-> ##[1:4] !motor_drive_fwd_o)
		else $error("motor past low range");
	lamp_blink_a: assert property (
		motor_drive_fwd_o && $changed(high_range_lamp_o) |=>
		($stable(high_range_lamp_o) || !motor_drive_fwd_o) [*8]) else $error("blink fast");
	timeout_off_a: assert property (
		$rose(timeout_fault_o) |-> ##[0:1] (!motor_drive_fwd_o && !motor_drive_rev_o) [*8])
		else $error("drive after timeout");
	comp_rev_a: assert property (
		$rose(encoder_fault_o) |-> ##[0:4] motor_drive_rev_o [*8]) else $error("no comp drive");
	fault_lamp_a: assert property (
		$rose(timeout_fault_o) || $rose(encoder_fault_o) |-> ##[0:3] fault_lamp_o)
		else $error("fault lamp dark");
	hub_delay_a: assert property (
		$rose(hub_solenoid_o) && high_range_lamp_o && !low_range_lamp_o |->
		$past(high_range_lamp_o && !motor_drive_fwd_o, HUB_LO)) else $error("hub early");
	cover property ($rose(motor_drive_fwd_o));
	cover property ($rose(timeout_fault_o));
	cover property ($rose(encoder_fault_o));
endmodule
bind transfer_controller transfer_controller_chk #(.TICK_CYCLES_P(TICK_CYCLES_P)) u_chk (
	.clock_i, .reset_i, .encoder_i, .motor_drive_fwd_o, .motor_drive_rev_o,
	.clutch_coil_drive_o, .hub_solenoid_o, .high_range_lamp_o, .low_range_lamp_o,
	.fault_lamp_o, .lamp_check_o, .timeout_fault_o, .encoder_fault_o);

// ==== tb/transfer_controller_tb.sv ====
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module transfer_controller_tb;
	import shift_pkg::*;
	localparam int TK = 4;
	logic clock_i = 1'h0, reset_i = 1'h1, ignition_i = 1'h1, select_2h_n_i = 1'h0;
	logic select_4l_n_i = 1'h1, clutch_pressed_i = 1'h0, neutral_i = 1'h0, battery_ok_i = 1'h1;
	logic stall = 1'h0, enc_bad = 1'h0, motor_ok_i = 1'h1;
	logic [7:0] speed_kph_i = 8'h00;
	logic [3:0] encoder_i;
	logic motor_drive_fwd_o, motor_drive_rev_o, clutch_coil_drive_o, hub_solenoid_o;
	logic high_range_lamp_o, low_range_lamp_o, fault_lamp_o, lamp_check_o;
	logic timeout_fault_o, encoder_fault_o;
	int n_fail = 0, tests_run = 0, el, cyc = 0;
	// short tick keeps second-scale intervals cheap
	transfer_controller #(.TICK_CYCLES_P(TK)) u_dut (.clock_i, .reset_i, .ignition_i,
		.select_2h_n_i, .select_4l_n_i, .encoder_i, .speed_kph_i, .clutch_pressed_i,
		.neutral_i, .battery_ok_i, .motor_ok_i, .motor_drive_fwd_o, .motor_drive_rev_o,
		.clutch_coil_drive_o, .hub_solenoid_o, .high_range_lamp_o, .low_range_lamp_o,
		.fault_lamp_o, .lamp_check_o, .timeout_fault_o, .encoder_fault_o);
	shift_motor_model u_motor (.clock_i, .fwd_i(motor_drive_fwd_o), .rev_i(motor_drive_rev_o),
		.stall_i(stall), .fault_i(enc_bad), .encoder_o(encoder_i));
	always #12.5 clock_i = ~clock_i;
	// hang guard, well above the roughly 2100 clocks the run needs
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			end_sim();
		end
	end
	function automatic bit probe(int w);
		case (w)
			0: return motor_drive_fwd_o;
			1: return !motor_drive_fwd_o;
			2: return motor_drive_rev_o;
			3: return !motor_drive_rev_o;
			4: return hub_solenoid_o;
			5: return !clutch_coil_drive_o;
			default: return timeout_fault_o;
		endcase
	endfunction
	// encoder code the plate must show when parked in a range
	function automatic logic [3:0] exp_code(range_t r);
		case (r)
			RANGE_2H: return POS_2H;
			RANGE_4H: return POS_4H;
			default: return POS_4L;
		endcase
	endfunction
	// bounded wait, sampled mid-cycle; el holds the clocks taken
	task automatic wu(int w, int lim);
		el = 0;
		do begin
			@(negedge clock_i);
			el++;
		end while (!probe(w) && el < lim * TK);
		`CHK(probe(w), 1'h1)
	endtask
	task automatic tk(int n);
		repeat (n * TK) @(posedge clock_i);
	endtask
	task automatic end_sim();
		if (n_fail == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// start-up, then shifts up, down, jammed and with a broken plate
	initial begin
		void'($urandom(64));
		tk(1);
		reset_i <= 1'h0;
		tk(3);
		@(negedge clock_i);
		`CHK({lamp_check_o, high_range_lamp_o, low_range_lamp_o}, 3'h7)
		`CHK({clutch_coil_drive_o, hub_solenoid_o}, 2'h3)
		tk(5);
		@(negedge clock_i);
		`CHK({lamp_check_o, clutch_coil_drive_o}, 2'h1)
		tk(10);
		@(negedge clock_i);
		`CHK({clutch_coil_drive_o, hub_solenoid_o, motor_drive_fwd_o}, 3'h0)
		@(posedge clock_i);
		speed_kph_i <= 8'($urandom_range(200));
		select_2h_n_i <= 1'h1;
		tk(4);
		@(negedge clock_i);
		`CHK({clutch_coil_drive_o, motor_drive_fwd_o}, 2'h2)
		wu(0, 60);
		`CHK(el >= 44 * TK, 1'h1)
		wu(1, 20);
		wu(4, 45);
		`CHK(el >= 37 * TK, 1'h1)
		`CHK({encoder_i, high_range_lamp_o}, {exp_code(RANGE_4H), 1'h1})
		wu(5, 55);
		`CHK(el >= 48 * TK, 1'h1)
		@(posedge clock_i);
		speed_kph_i <= 8'(2 + $urandom_range(100));
		clutch_pressed_i <= 1'h1;
		select_4l_n_i <= 1'h0;
		tk(40);
		@(negedge clock_i);
		`CHK(motor_drive_fwd_o, 1'h0)
		@(posedge clock_i);
		speed_kph_i <= 8'($urandom_range(1));
		clutch_pressed_i <= 1'h0;
		tk(30);
		@(negedge clock_i);
		`CHK(motor_drive_fwd_o, 1'h0)
		@(posedge clock_i);
		neutral_i <= 1'h1;
		wu(0, 30);
		@(posedge clock_i);
		ignition_i <= 1'h0;
		speed_kph_i <= 8'($urandom_range(255, 2));
		wu(1, 20);
		`CHK(encoder_i, exp_code(RANGE_4L))
		// a supply dip must restart the hold
		@(posedge clock_i);
		ignition_i <= 1'h1;
		speed_kph_i <= 8'h00;
		neutral_i <= 1'h0;
		select_4l_n_i <= 1'h1;
		tk(10);
		battery_ok_i <= 1'h0;
		tk(2);
		battery_ok_i <= 1'h1;
		tk(15);
		@(negedge clock_i);
		`CHK(motor_drive_rev_o, 1'h0)
		// a motor-circuit dip must restart the hold as well
		@(posedge clock_i);
		motor_ok_i <= 1'h0;
		tk(2);
		motor_ok_i <= 1'h1;
		tk(15);
		@(negedge clock_i);
		`CHK(motor_drive_rev_o, 1'h0)
		wu(2, 10);
		wu(3, 30);
		`CHK(encoder_i, exp_code(RANGE_4H))
		@(posedge clock_i);
		stall <= 1'h1;
		select_2h_n_i <= 1'h0;
		wu(2, 25);
		wu(6, 70);
		`CHK(el >= (int'(TIMEOUT_HL_T) - 2) * TK && el <= (int'(TIMEOUT_HL_T) + 2) * TK, 1'h1)
		tk(1);
		@(negedge clock_i);
		`CHK({motor_drive_rev_o, fault_lamp_o}, 2'h1)
		@(posedge clock_i);
		reset_i <= 1'h1;
		tk(1);
		reset_i <= 1'h0;
		wu(2, 80);
		`CHK({motor_drive_fwd_o, timeout_fault_o}, 2'h0)
		@(posedge clock_i);
		enc_bad <= 1'h1;
		tk(3);
		@(negedge clock_i);
		`CHK({encoder_fault_o, fault_lamp_o, motor_drive_rev_o}, 3'h7)
		tk(40);
		@(negedge clock_i);
		`CHK(motor_drive_rev_o, 1'h1)
		wu(3, 15);
		end_sim();
	end
endmodule
